// *** verilog/spcu_serial_port.sv ***
/*
  Serial port control and status with APB register access, mode 0 shifter,
  bit-rate selection and interrupt flags; instantiates spcu_tx and spcu_rx.
  Assumes timer overflow inputs are one-cycle pulses on clock_in.
*/
`timescale 1ns/100ps
// Function
// RULE1 - An invalid stop bit sets the framing error flag, which stays set until software writes it clear.
// RULE2 - Control bit 7 accesses the framing error flag when the access select is 1, else mode bit 0.
// RULE3 - The framing error flag is set regardless of the access select bit.
// RULE4 - Mode bits 00, 01, 10, 11 select shift register, 8-bit UART, fixed 9-bit UART, variable 9-bit UART.
// RULE5 - Mode 0 shifts at clock/6 or /3 in compatibility timing, /4 or /2 in fast timing, or from timer 1.
// RULE6 - Mode 2 bit time is 32 or 16 clocks; modes 1 and 3 take their rate from timer 1 or timer 2.
// RULE7 - The rate doubling bit picks the 16 or 32 divisor and the halved or doubled mode 0 rate.
// RULE8 - In modes 2 and 3 the transmit ninth bit is sent as the ninth data bit.
// RULE9 - The receive ninth bit holds the ninth data bit in modes 2 and 3 and the stop bit in mode 1.
// RULE10 - In modes 1 to 3 the transmit done flag is set at the start of the stop bit.
// RULE11 - In modes 1 to 3 the receive done flag is set halfway through the stop bit; software clears it.
// RULE12 - In mode 0 the done flags are set at the end of the eighth bit and stay set until cleared.
// RULE13 - Reception starts only with reception enabled: in mode 0 when receive done is 0, else on a start bit.
// RULE14 - In mode 0 a set transmit ninth bit makes timer 1 the shift clock source.
// RULE15 - In modes 2 and 3 with the filter bit set, receive done is raised only for a ninth bit of 1.
// RULE16 - In mode 1 with the filter bit set, receive done is raised only for a valid stop bit.
module spcu_serial_port #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              clock_in,
  input  wire logic              reset_n_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              timer1_overflow_in,
  input  wire logic              timer2_overflow_in,
  input  wire logic              rxd_in,
  output logic                   rxd_out,
  output logic                   rxd_oe_out,
  output logic                   txd_out,
  output logic                   irq_out
);

  if (ADDR_W < 8) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  logic                   mode_hi_reg, mode_lo_reg, filter_reg, ren_reg;
  logic                   tx9_reg, rx9_reg, tdone_reg, rdone_reg, fe_reg;
  logic                   double_reg, fe_sel_reg, t2sel_reg, fast_reg;
  logic [7:0]             rxbuf_reg;
  logic [2:0]             irq_stat_reg, irq_en_reg;
  spcu_pkg::spcu_mode_t   mode;
  logic [7:0]             addr8;
  logic                   acc_wr, mapped, wr_ctl, wr_data;
  logic [7:0]             ctl_view, pwr_view;
  logic [31:0]            rd_next;
  logic                   tick;
  logic [5:0]             bit_len;
  logic                   tx_busy, tx_stop_start, tx_line;
  logic                   rx_done, rx_bit9, rx_stop;
  logic [7:0]             rx_data;
  logic                   rx_accept;
  logic                   m0_active_reg, m0_rx_reg;
  logic [3:0]             m0_cnt_reg, m0_bits_reg, m0_per;
  logic [7:0]             m0_shift_reg;
  logic                   m0_adv, m0_end, m0_done, m0_start_tx, m0_start_rx;
  logic                   tset, rset, feset;

  function automatic logic [3:0] m0_period(input logic timer, input logic fast, input logic dbl);
    if (timer || fast) begin
      m0_period = dbl ? spcu_pkg::M0_DIV_FAST_X2 : spcu_pkg::M0_DIV_FAST;
    end else begin
      m0_period = dbl ? spcu_pkg::M0_DIV_COMPAT_X2 : spcu_pkg::M0_DIV_COMPAT;
    end
  endfunction

  assign mode    = spcu_pkg::spcu_mode_t'({mode_hi_reg, mode_lo_reg}); // RULE4
  assign addr8   = paddr_in[7:0];
  assign acc_wr  = psel_in && penable_in && pwrite_in;
  assign mapped  = (addr8 == spcu_pkg::OFS_CONTROL) || (addr8 == spcu_pkg::OFS_POWER) ||
                   (addr8 == spcu_pkg::OFS_DATA) || (addr8 == spcu_pkg::OFS_IRQ_STAT) ||
                   (addr8 == spcu_pkg::OFS_IRQ_CLR) || (addr8 == spcu_pkg::OFS_IRQ_EN);
  assign wr_ctl  = acc_wr && addr8 == spcu_pkg::OFS_CONTROL;
  assign wr_data = acc_wr && addr8 == spcu_pkg::OFS_DATA;
  assign pready_out = 1'b1;

  // Rate ticks and bit time
  assign tick    = (mode == spcu_pkg::MODE_UART9_FIXED) ? 1'b1 :
                   (t2sel_reg ? timer2_overflow_in : timer1_overflow_in); // RULE6
  assign bit_len = double_reg ? spcu_pkg::BIT_LEN_DOUBLE : spcu_pkg::BIT_LEN_NORMAL; // RULE7

  // Register read views
  assign ctl_view = {fe_sel_reg ? fe_reg : mode_hi_reg, mode_lo_reg, filter_reg, ren_reg, // RULE2
                     tx9_reg, rx9_reg, tdone_reg, rdone_reg};
  assign pwr_view = {double_reg, fe_sel_reg, 4'h0, t2sel_reg, fast_reg};

  always_comb begin
    rd_next = 32'h0;
    unique case (addr8)
      spcu_pkg::OFS_CONTROL:  rd_next = {24'h0, ctl_view};
      spcu_pkg::OFS_POWER:    rd_next = {24'h0, pwr_view};
      spcu_pkg::OFS_DATA:     rd_next = {24'h0, rxbuf_reg};
      spcu_pkg::OFS_IRQ_STAT: rd_next = {29'h0, irq_stat_reg};
      spcu_pkg::OFS_IRQ_EN:   rd_next = {29'h0, irq_en_reg};
      default:                rd_next = 32'h0;
    endcase
  end

  // APB answer registered in the setup cycle
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end else if (psel_in && !penable_in) begin
      prdata_out  <= pwrite_in ? 32'h0 : rd_next;
      pslverr_out <= !mapped;
    end
  end

  // Power control
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {double_reg, fe_sel_reg, t2sel_reg, fast_reg} <= {spcu_pkg::POWER_RESET[7:6], spcu_pkg::POWER_RESET[1:0]};
    end else if (acc_wr && addr8 == spcu_pkg::OFS_POWER) begin
      double_reg <= pwdata_in[spcu_pkg::PWR_DOUBLE];
      fe_sel_reg <= pwdata_in[spcu_pkg::PWR_FE_SEL];
      t2sel_reg  <= pwdata_in[spcu_pkg::PWR_T2SEL];
      fast_reg   <= pwdata_in[spcu_pkg::PWR_FAST];
    end
  end

  // Receive acceptance filter
  always_comb begin
    rx_accept = rx_done;
    if (filter_reg && mode == spcu_pkg::MODE_UART8) begin
      rx_accept = rx_done && rx_stop; // RULE16
    end else if (filter_reg && mode != spcu_pkg::MODE_SHIFT) begin
      rx_accept = rx_done && rx_bit9; // RULE15
    end
  end

  assign tset  = (m0_done && !m0_rx_reg) || tx_stop_start; // RULE10
  assign rset  = (m0_done && m0_rx_reg) || rx_accept; // RULE11
  assign feset = rx_done && !rx_stop; // RULE3

  // Control register; hardware set wins over software write
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {mode_hi_reg, mode_lo_reg, filter_reg, ren_reg} <= spcu_pkg::CONTROL_RESET[7:4];
      {tx9_reg, rx9_reg, tdone_reg, rdone_reg}       <= spcu_pkg::CONTROL_RESET[3:0];
      fe_reg                                         <= 1'b0;
    end else begin
      if (wr_ctl) begin
        if (fe_sel_reg) begin
          fe_reg <= pwdata_in[spcu_pkg::CTL_MODE0_FE]; // RULE2
        end else begin
          mode_hi_reg <= pwdata_in[spcu_pkg::CTL_MODE0_FE];
        end
        mode_lo_reg <= pwdata_in[spcu_pkg::CTL_MODE1];
        filter_reg  <= pwdata_in[spcu_pkg::CTL_FILTER];
        ren_reg     <= pwdata_in[spcu_pkg::CTL_REN];
        tx9_reg     <= pwdata_in[spcu_pkg::CTL_TX9];
        rx9_reg     <= pwdata_in[spcu_pkg::CTL_RX9];
        tdone_reg   <= pwdata_in[spcu_pkg::CTL_TDONE];
        rdone_reg   <= pwdata_in[spcu_pkg::CTL_RDONE];
      end
      if (feset) begin
        fe_reg <= 1'b1; // RULE1
      end
      if (tset) begin
        tdone_reg <= 1'b1; // RULE12
      end
      if (rset) begin
        rdone_reg <= 1'b1; // RULE12
      end
      if (rx_accept) begin
        rx9_reg <= (mode == spcu_pkg::MODE_UART8) ? rx_stop : rx_bit9; // RULE9
      end
    end
  end

  // Receive buffer
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rxbuf_reg <= spcu_pkg::DATA_RESET;
    end else if (m0_done && m0_rx_reg) begin
      rxbuf_reg <= m0_shift_reg;
    end else if (rx_accept) begin
      rxbuf_reg <= rx_data;
    end
  end

  // Mode 0 shift clock timing
  assign m0_per      = m0_period(tx9_reg, fast_reg, double_reg); // RULE5
  assign m0_adv      = m0_active_reg && (tx9_reg ? timer1_overflow_in : 1'b1); // RULE14
  assign m0_end      = m0_adv && (m0_cnt_reg == m0_per - 4'h1);
  assign m0_done     = m0_end && (m0_bits_reg == 4'h7);
  assign m0_start_tx = mode == spcu_pkg::MODE_SHIFT && wr_data && !m0_active_reg;
  assign m0_start_rx = mode == spcu_pkg::MODE_SHIFT && ren_reg && !rdone_reg && // RULE13
                       !m0_active_reg && !wr_data;

  // Mode 0 shifter
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      m0_active_reg <= 1'b0;
      m0_rx_reg     <= 1'b0;
      m0_cnt_reg    <= 4'h0;
      m0_bits_reg   <= 4'h0;
      m0_shift_reg  <= 8'h00;
      rxd_oe_out    <= 1'b0;
    end else if (m0_start_tx || m0_start_rx) begin
      m0_active_reg <= 1'b1;
      m0_rx_reg     <= m0_start_rx;
      m0_cnt_reg    <= 4'h0;
      m0_bits_reg   <= 4'h0;
      m0_shift_reg  <= m0_start_tx ? pwdata_in[7:0] : 8'h00;
      rxd_oe_out    <= m0_start_tx;
    end else if (m0_adv) begin
      m0_cnt_reg <= m0_end ? 4'h0 : m0_cnt_reg + 4'h1;
      if (m0_rx_reg && m0_cnt_reg == (m0_per >> 1)) begin
        m0_shift_reg <= {rxd_in, m0_shift_reg[7:1]};
      end
      if (m0_end) begin
        m0_bits_reg <= m0_bits_reg + 4'h1;
        if (!m0_rx_reg && !m0_done) begin
          m0_shift_reg <= {1'b0, m0_shift_reg[7:1]};
        end
        if (m0_done) begin
          m0_active_reg <= 1'b0;
          rxd_oe_out    <= 1'b0;
        end
      end
    end
  end

  assign rxd_out = m0_shift_reg[0];

  // Line output: shift clock in mode 0, data otherwise
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      txd_out <= 1'b1;
    end else if (mode == spcu_pkg::MODE_SHIFT) begin
      txd_out <= m0_active_reg ? ((m0_cnt_reg >= (m0_per >> 1)) ^ filter_reg) : !filter_reg;
    end else begin
      txd_out <= tx_line;
    end
  end

  spcu_tx #(
    .LEN_W (6)
  ) u_tx (
    .clock_in       (clock_in),
    .reset_n_in     (reset_n_in),
    .start_in       (wr_data && mode != spcu_pkg::MODE_SHIFT),
    .data_in        (pwdata_in[7:0]),
    .bit9_in        (tx9_reg),
    .nine_in        (mode_hi_reg),
    .tick_in        (tick),
    .len_in         (bit_len),
    .txd_out        (tx_line),
    .busy_out       (tx_busy),
    .stop_start_out (tx_stop_start)
  );

  spcu_rx #(
    .LEN_W (6)
  ) u_rx (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .enable_in  (ren_reg && mode != spcu_pkg::MODE_SHIFT),
    .rxd_in     (rxd_in),
    .nine_in    (mode_hi_reg),
    .tick_in    (tick),
    .len_in     (bit_len),
    .done_out   (rx_done),
    .data_out   (rx_data),
    .bit9_out   (rx_bit9),
    .stop_out   (rx_stop)
  );

  // Interrupt status, clear and enable
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_stat_reg <= spcu_pkg::IRQ_RESET;
      irq_en_reg   <= spcu_pkg::IRQ_RESET;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((acc_wr && addr8 == spcu_pkg::OFS_IRQ_CLR) ? pwdata_in[2:0] : 3'h0))
                      | {feset, rset, tset};
      if (acc_wr && addr8 == spcu_pkg::OFS_IRQ_EN) begin
        irq_en_reg <= pwdata_in[2:0];
      end
    end
  end

  assign irq_out = |(irq_stat_reg & irq_en_reg);

endmodule

// *** verilog/spcu_pkg.sv ***
/*
  Shared constants for the serial port: register map, field positions,
  reset values, bit-time counts and the mode type.
  Assumes a 32-bit APB slave with one register per aligned word.
*/
package spcu_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_POWER    = 8'h04;
  localparam logic [7:0] OFS_DATA     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;

  // Serial port control fields
  localparam int unsigned CTL_MODE0_FE = 7;
  localparam int unsigned CTL_MODE1    = 6;
  localparam int unsigned CTL_FILTER   = 5;
  localparam int unsigned CTL_REN      = 4;
  localparam int unsigned CTL_TX9      = 3;
  localparam int unsigned CTL_RX9      = 2;
  localparam int unsigned CTL_TDONE    = 1;
  localparam int unsigned CTL_RDONE    = 0;

  // Power control fields
  localparam int unsigned PWR_DOUBLE = 7;
  localparam int unsigned PWR_FE_SEL = 6;
  localparam int unsigned PWR_T2SEL  = 1;
  localparam int unsigned PWR_FAST   = 0;

  // Interrupt status, clear and enable fields
  localparam int unsigned IRQ_TX = 0;
  localparam int unsigned IRQ_RX = 1;
  localparam int unsigned IRQ_FE = 2;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] POWER_RESET   = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [2:0] IRQ_RESET     = 3'h0;

  // Bit times in rate ticks
  localparam logic [5:0] BIT_LEN_NORMAL   = 6'h20;
  localparam logic [5:0] BIT_LEN_DOUBLE   = 6'h10;
  localparam logic [3:0] M0_DIV_COMPAT    = 4'h6;
  localparam logic [3:0] M0_DIV_COMPAT_X2 = 4'h3;
  localparam logic [3:0] M0_DIV_FAST      = 4'h4;
  localparam logic [3:0] M0_DIV_FAST_X2   = 4'h2;

  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_UART8,
    MODE_UART9_FIXED,
    MODE_UART9_VAR
  } spcu_mode_t;

endpackage

// *** verilog/spcu_tx.sv ***
/*
  Asynchronous transmitter for 10 or 11 bit frames, LSB first.
  Assumes tick_in is a one-cycle rate pulse and len_in ticks make one bit.
*/
`timescale 1ns/100ps
module spcu_tx #(
  parameter int unsigned LEN_W = 6
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic             start_in,
  input  wire logic [7:0]       data_in,
  input  wire logic             bit9_in,
  input  wire logic             nine_in,
  input  wire logic             tick_in,
  input  wire logic [LEN_W-1:0] len_in,
  output logic                  txd_out,
  output logic                  busy_out,
  output logic                  stop_start_out
);

  if (LEN_W < 6) begin : g_chk
    $error("LEN_W too small for a 32 tick bit");
  end

  logic [10:0]      frame_reg;
  logic [LEN_W-1:0] cnt_reg;
  logic [3:0]       bitn_reg;
  logic [3:0]       last_bit;

  assign last_bit = nine_in ? 4'ha : 4'h9;
  assign txd_out  = frame_reg[0];

  // Frame shifter
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_reg      <= 11'h7ff;
      cnt_reg        <= '0;
      bitn_reg       <= 4'h0;
      busy_out       <= 1'b0;
      stop_start_out <= 1'b0;
    end else begin
      stop_start_out <= 1'b0;
      if (!busy_out && start_in) begin
        frame_reg <= {1'b1, nine_in ? bit9_in : 1'b1, data_in, 1'b0}; // RULE8
        cnt_reg   <= '0;
        bitn_reg  <= 4'h0;
        busy_out  <= 1'b1;
      end else if (busy_out && tick_in) begin
        if (cnt_reg == len_in - 1'b1) begin
          cnt_reg   <= '0;
          frame_reg <= {1'b1, frame_reg[10:1]};
          bitn_reg  <= bitn_reg + 4'h1;
          if (bitn_reg + 4'h1 == last_bit) begin
            stop_start_out <= 1'b1; // RULE10
          end
          if (bitn_reg == last_bit) begin
            busy_out <= 1'b0;
          end
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule

// *** verilog/spcu_rx.sv ***
/*
  Asynchronous receiver for 8 or 9 data bits with mid-bit sampling.
  Assumes rxd_in is synchronous and tick_in is a one-cycle rate pulse.
*/
`timescale 1ns/100ps
module spcu_rx #(
  parameter int unsigned LEN_W = 6
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic             enable_in,
  input  wire logic             rxd_in,
  input  wire logic             nine_in,
  input  wire logic             tick_in,
  input  wire logic [LEN_W-1:0] len_in,
  output logic                  done_out,
  output logic [7:0]            data_out,
  output logic                  bit9_out,
  output logic                  stop_out
);

  if (LEN_W < 6) begin : g_chk
    $error("LEN_W too small for a 32 tick bit");
  end

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spcu_rx_state_t;

  spcu_rx_state_t   state_reg;
  logic [LEN_W-1:0] cnt_reg;
  logic [3:0]       bitn_reg;
  logic [8:0]       shift_reg;
  logic             bit_end;
  logic             half_end;

  assign bit_end  = tick_in && (cnt_reg == len_in - 1'b1);
  assign half_end = tick_in && (cnt_reg == (len_in >> 1) - 1'b1);

  // Frame receiver
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= RX_IDLE;
      cnt_reg   <= '0;
      bitn_reg  <= 4'h0;
      shift_reg <= 9'h000;
      done_out  <= 1'b0;
      data_out  <= 8'h00;
      bit9_out  <= 1'b0;
      stop_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (tick_in && state_reg != RX_IDLE) begin
        cnt_reg <= bit_end ? '0 : cnt_reg + 1'b1;
      end
      unique case (state_reg)
        RX_IDLE: begin
          if (enable_in && !rxd_in) begin // RULE13
            state_reg <= RX_START;
            cnt_reg   <= '0;
          end
        end
        RX_START: begin
          if (half_end) begin
            cnt_reg   <= '0;
            bitn_reg  <= 4'h0;
            state_reg <= rxd_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (bit_end) begin
            shift_reg <= {rxd_in, shift_reg[8:1]};
            bitn_reg  <= bitn_reg + 4'h1;
            if (bitn_reg == (nine_in ? 4'h8 : 4'h7)) begin
              state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (bit_end) begin
            done_out  <= 1'b1; // RULE11
            stop_out  <= rxd_in;
            data_out  <= nine_in ? shift_reg[7:0] : shift_reg[8:1];
            bit9_out  <= shift_reg[8];
            state_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// *** sim/spcu_serial_port_asserts.sv ***
/*
  Port checker for the serial port.
  Assumes a bind into spcu_serial_port, one clock.
*/
`timescale 1ns/100ps
module spcu_serial_port_asserts #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              clock_in,
  input wire logic              reset_n_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic              txd_out,
  input wire logic              rxd_oe_out,
  input wire logic              irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic [7:0] pwr_q;
  logic [7:0] ctl_q;
  logic [2:0] en_q;
  logic [1:0] mode_q;
  logic [5:0] low_cnt;
  wire logic  setup = psel_in & ~penable_in;
  wire logic  wr = psel_in & penable_in & pwrite_in;
  wire logic  mapped = paddr_in[1:0] == 2'h0 && paddr_in <= spcu_pkg::OFS_IRQ_EN;
  // Register shadows
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwr_q <= 8'h00;
      ctl_q <= 8'h00;
      en_q <= 3'h0;
      mode_q <= 2'h0;
    end else if (wr) begin
      if (paddr_in == spcu_pkg::OFS_POWER) pwr_q <= pwdata_in[7:0];
      if (paddr_in == spcu_pkg::OFS_IRQ_EN) en_q <= pwdata_in[2:0];
      if (paddr_in == spcu_pkg::OFS_CONTROL) begin
        ctl_q <= pwdata_in[7:0];
        mode_q <= {pwr_q[6] ? mode_q[1] : pwdata_in[7], pwdata_in[6]};
      end
    end
  end
  // Length of the current low run on txd
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) low_cnt <= 6'h00;
    else low_cnt <= txd_out ? 6'h00 : low_cnt + 6'h01;
  end
  sequence s_low_half;
    !txd_out [*3] ##1 txd_out;
  endsequence
  a_ready_high: assert property (pready_out) else $error("pready low");
  a_slverr_map: assert property (setup |=> pslverr_out == !mapped) else $error("slave error wrong");
  a_clear_zero: assert property (setup && !pwrite_in && (!mapped || paddr_in == spcu_pkg::OFS_IRQ_CLR)
    |=> prdata_out == 32'h0) else $error("read data not zero");
  a_mode_read: assert property (setup && !pwrite_in && paddr_in == spcu_pkg::OFS_CONTROL && !pwr_q[6]
    |=> prdata_out[7:6] == mode_q) else $error("mode bits wrong");
  a_power_read: assert property (setup && !pwrite_in && paddr_in == spcu_pkg::OFS_POWER
    |=> prdata_out[7:6] == pwr_q[7:6]) else $error("power bits wrong");
  a_irq_mask: assert property (en_q == 3'h0 |-> !irq_out) else $error("irq while masked");
  a_oe_mode: assert property (rxd_oe_out |-> mode_q == 2'h0 || $past(mode_q) == 2'h0)
    else $error("rxd driven off mode 0");
  a_bit_len: assert property ($rose(txd_out) && mode_q == 2'h2
    |-> (pwr_q[7] ? low_cnt[3:0] : low_cnt[4:0]) == 5'h00) else $error("bit time wrong");
  a_shift_half: assert property ($fell(txd_out) && mode_q == 2'h0 && pwr_q[7] == 1'b0 && pwr_q[0] == 1'b0
    && ctl_q[5] == 1'b0 && ctl_q[3] == 1'b0 |-> s_low_half) else $error("shift phase wrong");
endmodule

// *** sim/spcu_remote.sv ***
/*
  Far-end serial device: sends and samples frames.
  Assumes bit lengths in clock cycles.
*/
`timescale 1ns/100ps
module spcu_remote (
  input  wire logic clock_in,
  input  wire logic line_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  // Frame out LSB first, then idle high
  task automatic send(input logic [10:0] bits, input int n, input int len);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_in);
      line_out <= bits[i];
      repeat (len - 1) @(posedge clock_in);
    end
    @(posedge clock_in);
    line_out <= 1'b1;
    repeat (len) @(posedge clock_in);
  endtask
  // Frame in; returns mid last bit
  task automatic recv(input int n, input int len, output logic [10:0] bits);
    bits = 11'h7ff;
    wait (line_in == 1'b0);
    repeat (len / 2) @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      bits[i] = line_in;
      if (i < n - 1) repeat (len) @(posedge clock_in);
    end
  endtask
endmodule

// *** sim/testbench.sv ***
/*
  Serial port testbench: APB tasks, far-end model and checks.
  Assumes the checker and far-end model are compiled first.
*/
`timescale 1ns/100ps
module testbench;
  logic        clock_in;
  logic        reset_n_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer1;
  logic        rxd_d;
  logic        rxd_oe;
  logic        far_rxd;
  logic        txd;
  logic        irq;
  wire logic   rxd = rxd_oe ? rxd_d : far_rxd;
  logic [10:0] bits;
  logic [31:0] q;
  logic        e;
  realtime     t0;
  int          err_count = 0;
  int          num_checks = 0;
  localparam logic [7:0] CTL = spcu_pkg::OFS_CONTROL, PWR = spcu_pkg::OFS_POWER, DAT = spcu_pkg::OFS_DATA;

  spcu_serial_port i_dut (
    .clock_in, .reset_n_in, .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .timer1_overflow_in(timer1), .timer2_overflow_in(1'b0), .rxd_in(rxd),
    .rxd_out(rxd_d), .rxd_oe_out(rxd_oe), .txd_out(txd), .irq_out(irq)
  );
  spcu_remote i_far (.clock_in, .line_in(txd), .line_out(far_rxd));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) timer1 <= ~timer1;

  task automatic check(input string s, input logic [31:0] seen, input logic [31:0] x);
    num_checks++;
    if (seen !== x) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", s, x, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string s);
    apb(1'b0, a, 32'h0);
    check(s, q & m, x);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock_in);
    err_count++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, timer1, reset_n_in} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rdc(CTL, 32'hff, {24'h0, spcu_pkg::CONTROL_RESET}, "control reset");
    rdc(PWR, 32'hff, {24'h0, spcu_pkg::POWER_RESET}, "power reset");
    rdc(spcu_pkg::OFS_IRQ_CLR, 32'hffffffff, 32'h0, "clear read");
    rdc(8'h18, 32'hffffffff, 32'h0, "unmapped");
    check("unmapped error", 32'(e), 32'h1);
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      wr(PWR, k ? 32'h80 : 32'h00);
      wr(CTL, k ? 32'h80 : 32'h88);
      wr(spcu_pkg::OFS_IRQ_EN, 32'h1);
      wr(DAT, 32'ha5);
      i_far.recv(11, k ? spcu_pkg::BIT_LEN_DOUBLE : spcu_pkg::BIT_LEN_NORMAL, bits);
      check("tx frame", 32'(bits), {21'h0, 1'b1, k == 0, 8'ha5, 1'b0});
      rdc(CTL, 32'h2, 32'h2, "tx done");
      check("irq raised", 32'(irq), 32'h1);
      wr(spcu_pkg::OFS_IRQ_EN, 32'h0);
      @(negedge clock_in);
      check("irq masked", 32'(irq), 32'h0);
      wr(spcu_pkg::OFS_IRQ_EN, 32'h1);
      wr(spcu_pkg::OFS_IRQ_CLR, 32'h1);
      @(negedge clock_in);
      check("irq cleared", 32'(irq), 32'h0);
      repeat (32) @(posedge clock_in);
    end
    $display("test transmit done");
    wr(PWR, 32'h0);
    wr(CTL, 32'h80);
    i_far.send(11'h6ee, 11, 32);
    rdc(CTL, 32'h1, 32'h0, "rx disabled");
    wr(CTL, 32'h90);
    i_far.send(11'h678, 11, 32);
    rdc(DAT, 32'hff, 32'h3c, "rx data");
    rdc(CTL, 32'h5, 32'h5, "rx9 done");
    wr(CTL, 32'hb0);
    i_far.send(11'h422, 11, 32);
    rdc(CTL, 32'h1, 32'h0, "filtered");
    i_far.send(11'h6b4, 11, 32);
    rdc(DAT, 32'hff, 32'h5a, "addr frame");
    $display("test receive done");
    wr(CTL, 32'h90);
    i_far.send(11'h244, 11, 32);
    rdc(spcu_pkg::OFS_IRQ_STAT, 32'h4, 32'h4, "fe status");
    wr(PWR, 32'h40);
    i_far.send(11'h666, 11, 32);
    rdc(CTL, 32'h80, 32'h80, "fe kept");
    wr(CTL, 32'h10);
    rdc(CTL, 32'h80, 32'h0, "fe cleared");
    wr(PWR, 32'h0);
    rdc(CTL, 32'hc0, 32'h80, "mode visible");
    $display("test framing done");
    wr(CTL, 32'h70);
    i_far.send(11'h444, 10, 2 * spcu_pkg::BIT_LEN_NORMAL);
    rdc(CTL, 32'h1, 32'h0, "m1 bad stop");
    // Low stop line may restart the receiver
    repeat (22 * spcu_pkg::BIT_LEN_NORMAL) @(posedge clock_in);
    wr(CTL, 32'h50);
    i_far.send(11'h688, 10, 2 * spcu_pkg::BIT_LEN_NORMAL);
    rdc(CTL, 32'h5, 32'h5, "m1 stop");
    rdc(DAT, 32'hff, 32'h44, "m1 data");
    $display("test mode 1 done");
    wr(CTL, 32'h00);
    wr(DAT, 32'h96);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      bits[i] = rxd;
      if (i == 0) t0 = $realtime;
    end
    check("shift period", 32'($realtime - t0), 7 * spcu_pkg::M0_DIV_COMPAT * 25);
    check("shift data", {24'h0, bits[7:0]}, 32'h96);
    repeat (spcu_pkg::M0_DIV_COMPAT) @(posedge clock_in);
    rdc(CTL, 32'h2, 32'h2, "shift tx done");
    $display("test mode 0 done");
    conclude();
  end
endmodule

bind spcu_serial_port spcu_serial_port_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .clock_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .pready_out, .pslverr_out, .txd_out, .rxd_oe_out, .irq_out
);
